/* prd_checker_sva.sv */
`timescale 1ns/1ns
module prd_checker #(
	parameter int ENABLE_WAIT_CYC = 100 // wait after enable
) (
	input  wire logic clk,            // clock
	input  wire logic sys_rst,        // sync reset
	input  wire logic step_pulse_in,  // step line
	input  wire logic dir_in,         // direction line
	input  wire logic error_clear_in, // clear line
	input  wire logic drive_enable    // servo on
);
	localparam int CLR_HOLD = 2500; // 20 us at 8 ns
	localparam int MIN_HALF = 125;  // 1 us at 8 ns
	int en_cnt_q;
	int clr_gap_q;
	int stp_gap_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			en_cnt_q <= 0;
			clr_gap_q <= CLR_HOLD;
			stp_gap_q <= MIN_HALF;
		end else begin
			en_cnt_q <= !drive_enable ? 0 : (en_cnt_q < ENABLE_WAIT_CYC ? en_cnt_q + 1 : en_cnt_q);
			clr_gap_q <= $changed(error_clear_in) ? 0 : (clr_gap_q < CLR_HOLD ? clr_gap_q + 1 : clr_gap_q);
			stp_gap_q <= $changed(step_pulse_in) ? 0 : (stp_gap_q < MIN_HALF ? stp_gap_q + 1 : stp_gap_q);
		end
	end
	AST_CLR_HOLD: assert property ($changed(error_clear_in) |-> clr_gap_q >= CLR_HOLD - 1)
		else $error("clear line level held too briefly");
	AST_CLR_STEADY: assert property ($changed(error_clear_in) |=> $stable(error_clear_in)[*8])
		else $error("clear line toggles again at once");
	AST_STEP_GAP: assert property ($changed(step_pulse_in) |-> stp_gap_q >= MIN_HALF - 1)
		else $error("step line edges closer than rate limit");
	AST_NO_TWIN: assert property (!($changed(step_pulse_in) && $changed(dir_in)))
		else $error("step and direction lines change together");
	AST_EN_WAIT: assert property (drive_enable && en_cnt_q < ENABLE_WAIT_CYC |-> $stable(step_pulse_in))
		else $error("step sent before enable wait ran out");
	AST_OFF_QUIET: assert property (!drive_enable |-> $stable(step_pulse_in))
		else $error("step sent while drive disabled");
endmodule

/* prd_defines.svh */
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH

// pulse form codes
`define PRD_FORM_SIGN_POS   4'h0
`define PRD_FORM_NEG_BASE   4'h5
`define PRD_FORM_MAX        4'h9
// clear form codes
`define PRD_CLR_LEVEL_HIGH  2'h0
`define PRD_CLR_RISE        2'h1
`define PRD_CLR_LEVEL_LOW   2'h2
`define PRD_CLR_FALL        2'h3
// counter width
`define PRD_ERR_W           32
// clock 125 MHz
`define PRD_CLK_HZ          125000000
// host timing, figures as printed
`define PRD_ENABLE_WAIT_MS  40
`define PRD_CLEAR_HOLD_US   20
`define PRD_ENABLE_WAIT_CYC ((`PRD_CLK_HZ / 1000) * `PRD_ENABLE_WAIT_MS)
`define PRD_CLEAR_HOLD_CYC  ((`PRD_CLK_HZ / 1000000) * `PRD_CLEAR_HOLD_US)
// host step period: 500 kpps -> 2000 ns, 400 kpps, 200 kpps
`define PRD_RATE_X1_KPPS    500
`define PRD_RATE_X2_KPPS    400
`define PRD_RATE_X4_KPPS    200
`define PRD_HALF_X1_CYC     ((`PRD_CLK_HZ / (`PRD_RATE_X1_KPPS * 1000)) / 2)
`define PRD_HALF_X2_CYC     ((`PRD_CLK_HZ / (`PRD_RATE_X2_KPPS * 1000)) / 2)
`define PRD_HALF_X4_CYC     ((`PRD_CLK_HZ / (`PRD_RATE_X4_KPPS * 1000)) / 2)

`endif

/* prd_device.sv */
// Operation
// - form 0-4 positive, 5-9 negative logic
// - sign+pulse: pulse steps, sign gives direction
// - cw pulses forward, ccw pulses reverse
// - quadrature: b leading a is forward
// - x1/x2/x4 multiply only in quadrature
// - host keeps step rate within limits
// - motion proportional to net step count
// - host waits 40 ms after enable
// - host holds clear at least 20 us
// - clear zeroes counter; level forms 0 and 2 also inhibit position loop
// - form 1: clear once on rising edge
// - form 3: clear once on falling edge
// - filter 1 advised for open-collector noise
`timescale 1ns/1ns
`include "prd_defines.svh"
module prd_device (
	input  wire logic                   clk,                 // 125 MHz clock
	input  wire logic                   sys_rst,             // sync reset, active high
	prd_link_if.device                  link,                // pins from host
	input  wire logic [3:0]             pulse_form_select,   // 0..9
	input  wire logic [1:0]             clear_form_select,   // 0..3
	input  wire logic                   input_filter_select, // 1: extra glitch filter
	input  wire logic                   fb_step,             // motor feedback count
	input  wire logic                   fb_dir,              // feedback reverse when high
	output logic signed [`PRD_ERR_W-1:0] error_count_q,      // position error counter
	output logic signed [`PRD_ERR_W-1:0] ref_position_q,     // net reference steps
	output logic                        loop_inhibit_q,      // position loop held off
	output logic                        ref_step_q,          // one-cycle decoded step
	output logic                        ref_rev_q            // direction of ref_step_q
);
	logic [1:0] a_sync_q, b_sync_q, c_sync_q;
	logic [1:0] a_flt_q, b_flt_q, c_flt_q;
	logic       a_q, b_q, c_q;

	// two sync flops and a two-flop history, then optional two-sample agreement filter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			a_sync_q <= 2'h0;
			b_sync_q <= 2'h0;
			c_sync_q <= 2'h0;
		end else begin
			a_sync_q <= {a_sync_q[0], link.step_pulse_in};
			b_sync_q <= {b_sync_q[0], link.dir_in};
			c_sync_q <= {c_sync_q[0], link.error_clear_in};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			a_flt_q <= 2'h0;
			b_flt_q <= 2'h0;
			c_flt_q <= 2'h0;
		end else begin
			a_flt_q <= {a_flt_q[0], a_sync_q[1]};
			b_flt_q <= {b_flt_q[0], b_sync_q[1]};
			c_flt_q <= {c_flt_q[0], c_sync_q[1]};
		end
	end

	function automatic logic filt(input logic [1:0] h, input logic prev, input logic en);
		filt = en ? ((h[1] == h[0]) ? h[0] : prev) : h[0];
	endfunction

	wire a_now = filt(a_flt_q, a_q, input_filter_select);
	wire b_now = filt(b_flt_q, b_q, input_filter_select);
	wire c_now = filt(c_flt_q, c_q, input_filter_select);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			c_q <= 1'b0;
		end else begin
			a_q <= a_now;
			b_q <= b_now;
			c_q <= c_now;
		end
	end

	// form decode
	wire       neg_logic = (pulse_form_select >= `PRD_FORM_NEG_BASE);
	wire [3:0] form_rel  = neg_logic ? (pulse_form_select - `PRD_FORM_NEG_BASE)
	                                 : pulse_form_select;
	wire       form_ok   = (pulse_form_select <= `PRD_FORM_MAX);
	prd_pkg::prd_form_t form;
	assign form = (form_rel == 4'h0) ? prd_pkg::PRD_SIGN_PULSE :
	              (form_rel == 4'h1) ? prd_pkg::PRD_DUAL_PULSE : prd_pkg::PRD_QUAD;
	wire       mul_x2    = (form_rel == 4'h3);
	wire       mul_x4    = (form_rel == 4'h4);

	// logic-corrected levels; edges taken after synchronisation
	wire la_now  = a_now ^ neg_logic;
	wire la_prev = a_q ^ neg_logic;
	wire lb_now  = b_now ^ neg_logic;
	wire lb_prev = b_q ^ neg_logic;
	wire a_rise  = la_now & ~la_prev;
	wire a_fall  = ~la_now & la_prev;
	wire b_rise  = lb_now & ~lb_prev;
	wire b_fall  = ~lb_now & lb_prev;

	// sign + pulse: count on active edge of step line
	wire sp_step = a_rise;
	wire sp_rev  = ~lb_now;

	// cw on step line forward, ccw on direction line reverse
	wire dp_fwd  = a_rise & ~b_rise;
	wire dp_revs = b_rise & ~a_rise;

	// quadrature: b leads a -> forward
	wire q_b_edge = b_rise | b_fall;
	wire q_a_edge = a_rise | a_fall;
	wire q_fwd_b  = q_b_edge & (lb_now != la_now);
	wire q_fwd_a  = q_a_edge & (la_now == lb_now);
	wire q_x1     = a_rise;
	wire q_x2     = q_a_edge;
	wire q_x4     = q_a_edge | q_b_edge;
	wire q_step   = mul_x4 ? q_x4 : (mul_x2 ? q_x2 : q_x1);
	wire q_rev    = q_a_edge ? ~q_fwd_a : ~q_fwd_b;

	wire step_d = form_ok & ((form == prd_pkg::PRD_SIGN_PULSE) ? sp_step :
	                         (form == prd_pkg::PRD_DUAL_PULSE) ? (dp_fwd | dp_revs) : q_step);
	wire rev_d  = (form == prd_pkg::PRD_SIGN_PULSE) ? sp_rev :
	              (form == prd_pkg::PRD_DUAL_PULSE) ? dp_revs : q_rev;

	// clear decode on synchronised level
	wire c_rise = c_now & ~c_q;
	wire c_fall = ~c_now & c_q;
	wire clr_active =
		(clear_form_select == `PRD_CLR_LEVEL_HIGH) ? c_now :
		(clear_form_select == `PRD_CLR_RISE)       ? c_rise :
		(clear_form_select == `PRD_CLR_LEVEL_LOW)  ? ~c_now :
		                                             c_fall;
	wire clr_level = (clear_form_select == `PRD_CLR_LEVEL_HIGH) |
	                 (clear_form_select == `PRD_CLR_LEVEL_LOW);

	wire signed [`PRD_ERR_W-1:0] ref_delta = step_d ? (rev_d ? -32'sd1 : 32'sd1) : 32'sd0;
	wire signed [`PRD_ERR_W-1:0] fb_delta  = fb_step ? (fb_dir ? -32'sd1 : 32'sd1) : 32'sd0;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			error_count_q <= '0;
		end else if (clr_active) begin
			error_count_q <= '0;
		end else begin
			error_count_q <= error_count_q + ref_delta - fb_delta;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ref_position_q <= '0;
			ref_step_q     <= 1'b0;
			ref_rev_q      <= 1'b0;
			loop_inhibit_q <= 1'b0;
		end else begin
			ref_position_q <= ref_position_q + ref_delta;
			ref_step_q     <= step_d;
			ref_rev_q      <= rev_d;
			loop_inhibit_q <= clr_level & clr_active;
		end
	end
endmodule

/* prd_host.sv */
`timescale 1ns/1ns
`include "prd_defines.svh"
module prd_host #(
	parameter int ENABLE_WAIT_CYC = `PRD_ENABLE_WAIT_CYC  // wait after enable
) (
	input  wire logic       clk,            // 125 MHz clock
	input  wire logic       sys_rst,        // sync reset, active high
	prd_link_if.host        link,           // pins to device
	input  wire logic [3:0] pulse_form,     // same code as device select
	input  wire logic       enable_req,     // request drive enable
	input  wire logic       move_req,       // one-cycle: issue one step
	input  wire logic       move_rev,       // direction of the step
	input  wire logic       clear_req,      // one-cycle: issue a clear
	input  wire logic       clear_pol,      // idle level of clear pin
	output logic            move_ready_q,   // may accept move_req
	output logic            clear_busy_q    // clear pulse in progress
);
	localparam logic [15:0] HALF_X1  = 16'(`PRD_HALF_X1_CYC);
	localparam logic [15:0] HALF_X2  = 16'(`PRD_HALF_X2_CYC);
	localparam logic [15:0] HALF_X4  = 16'(`PRD_HALF_X4_CYC);
	localparam logic [15:0] CLR_HOLD = 16'(`PRD_CLEAR_HOLD_CYC);
	localparam logic [31:0] EN_WAIT  = 32'(ENABLE_WAIT_CYC);

	prd_pkg::prd_host_state_t state_q, state_d;
	logic [31:0] en_cnt_q;
	logic        enable_q, line_a_q, line_b_q, line_c_q;
	logic        busy_q, fired_q, rev_q, pend_q, pulse_q;
	logic [2:0]  quad_left_q;
	logic [15:0] gap_q, clr_gap_q;

	assign link.step_pulse_in  = line_a_q;
	assign link.dir_in         = line_b_q;
	assign link.error_clear_in = line_c_q;
	assign link.drive_enable   = enable_q;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			prd_pkg::PRD_HS_IDLE: if (enable_q) state_d = prd_pkg::PRD_HS_WAIT;
			prd_pkg::PRD_HS_WAIT: begin
				if (!enable_q) state_d = prd_pkg::PRD_HS_IDLE;
				else if (en_cnt_q >= EN_WAIT) state_d = prd_pkg::PRD_HS_RUN;
			end
			prd_pkg::PRD_HS_RUN: if (!enable_q) state_d = prd_pkg::PRD_HS_IDLE;
			default: state_d = prd_pkg::PRD_HS_IDLE;
		endcase
	end

	// steps work on logical levels, lines keep their physical level
	wire        neg     = (pulse_form >= `PRD_FORM_NEG_BASE);
	wire [3:0]  rel     = neg ? (pulse_form - `PRD_FORM_NEG_BASE) : pulse_form;
	wire        la      = line_a_q ^ neg;
	wire        lb      = line_b_q ^ neg;
	wire        is_sp   = (rel == 4'h0);
	wire        is_dp   = (rel == 4'h1);
	wire [15:0] half    = (rel == 4'h3) ? HALF_X2 : ((rel == 4'h4) ? HALF_X4 : HALF_X1);
	wire [2:0]  quad_n  = (rel == 4'h3) ? 3'h2 : ((rel == 4'h4) ? 3'h1 : 3'h4);
	wire        sp_tb   = (lb == rev_q);
	wire        dp_oact = rev_q ? la : lb;
	wire        dp_pact = rev_q ? lb : la;
	wire        dp_ta   = dp_oact ? rev_q : ~rev_q;
	wire        q_tb    = rev_q ? (la != lb) : (la == lb);
	wire        op_tb   = is_sp ? sp_tb : (is_dp ? ~dp_ta : q_tb);
	wire        own_act = is_sp ? la : dp_pact;
	wire        pre_ok  = is_sp ? ~sp_tb : ~dp_oact;
	wire        op_fire = (is_sp | is_dp) & pre_ok & ~fired_q & ~own_act;
	wire        op_done = (is_sp | is_dp) ? (pre_ok & fired_q) : (quad_left_q == 3'h1);
	wire        do_op   = busy_q & (gap_q >= half);
	wire        start   = move_req & move_ready_q;
	wire        busy_d  = start | (busy_q & ~(do_op & op_done));

	// clear line: every level change spaced by the hold time
	wire        clr_ok    = (clr_gap_q >= CLR_HOLD);
	wire        clr_end   = clr_ok & pulse_q;
	wire        clr_idle  = clr_ok & ~pulse_q & (line_c_q != clear_pol);
	wire        clr_start = clr_ok & ~pulse_q & (line_c_q == clear_pol) & pend_q;
	wire        clr_move  = clr_end | clr_idle | clr_start;
	wire        pend_d    = (pend_q & ~clr_start) | clear_req;
	wire        pulse_d   = (pulse_q & ~clr_end) | clr_start;
	wire        line_c_d  = clr_move ? (clr_start ? ~clear_pol : clear_pol) : line_c_q;
	wire [15:0] clr_gap_d = clr_move ? 16'h0 : (clr_ok ? clr_gap_q : clr_gap_q + 16'h1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q      <= prd_pkg::PRD_HS_IDLE;
			en_cnt_q     <= 32'h0;
			enable_q     <= 1'b0;
			move_ready_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			en_cnt_q     <= (state_q == prd_pkg::PRD_HS_WAIT) ? en_cnt_q + 32'h1 : 32'h0;
			enable_q     <= enable_req;
			move_ready_q <= (state_q == prd_pkg::PRD_HS_RUN) & ~busy_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			line_a_q    <= 1'b0;
			line_b_q    <= 1'b0;
			busy_q      <= 1'b0;
			fired_q     <= 1'b0;
			rev_q       <= 1'b0;
			quad_left_q <= 3'h0;
			gap_q       <= 16'h0;
		end else begin
			gap_q <= do_op ? 16'h0 : ((gap_q != 16'hffff) ? gap_q + 16'h1 : gap_q);
			if (start) begin
				busy_q      <= 1'b1;
				fired_q     <= 1'b0;
				rev_q       <= move_rev;
				quad_left_q <= quad_n;
			end else if (do_op) begin
				line_a_q    <= line_a_q ^ ~op_tb;
				line_b_q    <= line_b_q ^ op_tb;
				fired_q     <= fired_q | op_fire;
				quad_left_q <= quad_left_q - 3'h1;
				busy_q      <= ~op_done;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			line_c_q     <= 1'b0;
			pend_q       <= 1'b0;
			pulse_q      <= 1'b0;
			clr_gap_q    <= CLR_HOLD;
			clear_busy_q <= 1'b0;
		end else begin
			line_c_q     <= line_c_d;
			pend_q       <= pend_d;
			pulse_q      <= pulse_d;
			clr_gap_q    <= clr_gap_d;
			clear_busy_q <= pend_d | pulse_d | (line_c_d != clear_pol) | (clr_gap_d < CLR_HOLD);
		end
	end
endmodule

/* prd_link_if.sv */
`timescale 1ns/1ns
interface prd_link_if;
	logic step_pulse_in;   // pulse / cw / phase a
	logic dir_in;          // sign / ccw / phase b
	logic error_clear_in;  // error counter clear
	logic drive_enable;    // servo on from host

	modport device (
		input step_pulse_in,
		input dir_in,
		input error_clear_in,
		input drive_enable
	);
	modport host (
		output step_pulse_in,
		output dir_in,
		output error_clear_in,
		output drive_enable
	);
endinterface

/* prd_pkg.sv */
package prd_pkg;
	typedef enum logic [1:0] {
		PRD_SIGN_PULSE = 2'b00,
		PRD_DUAL_PULSE = 2'b01,
		PRD_QUAD       = 2'b10
	} prd_form_t;

	typedef enum logic [1:0] {
		PRD_HS_IDLE  = 2'b00,
		PRD_HS_WAIT  = 2'b01,
		PRD_HS_RUN   = 2'b10
	} prd_host_state_t;
endpackage

/* pulse_reference_decoder_bench.sv */
`timescale 1ns/1ns
`include "prd_defines.svh"
module pulse_reference_decoder_bench;
	localparam int WAIT_CYC = 200;
	logic                         clk, sys_rst, filt, fb_step, fb_dir, en_req, mv_req, mv_rev;
	logic                         clr_req, clr_pol, inh_q, ready, cbusy;
	logic [3:0]                   form;
	logic [1:0]                   clr_form;
	logic signed [`PRD_ERR_W-1:0] err_q, pos_q;
	int                           err_count, samples_checked, seed, exp_pos, exp_err, i, k;
	prd_link_if link ();
	prd_host #(.ENABLE_WAIT_CYC(WAIT_CYC)) prd_host_inst (.clk(clk), .sys_rst(sys_rst),
		.link(link), .pulse_form(form), .enable_req(en_req), .move_req(mv_req),
		.move_rev(mv_rev), .clear_req(clr_req), .clear_pol(clr_pol), .move_ready_q(ready),
		.clear_busy_q(cbusy));
	prd_device prd_device_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
		.pulse_form_select(form), .clear_form_select(clr_form), .input_filter_select(filt),
		.fb_step(fb_step), .fb_dir(fb_dir), .error_count_q(err_q), .ref_position_q(pos_q),
		.loop_inhibit_q(inh_q), .ref_step_q(), .ref_rev_q());
	prd_checker #(.ENABLE_WAIT_CYC(WAIT_CYC)) prd_checker_inst (.clk(clk), .sys_rst(sys_rst),
		.step_pulse_in(link.step_pulse_in), .dir_in(link.dir_in),
		.error_clear_in(link.error_clear_in), .drive_enable(link.drive_enable));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic signed [`PRD_ERR_W-1:0] got, input int exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask
	// sel 0: wait move ready, sel 1: wait clear pulse over
	task automatic wait_on(input bit sel);
		for (k = 0; k < 6000 && (sel ? cbusy !== 1'b0 : ready !== 1'b1); k++) tick(1);
		if (k == 6000) begin
			err_count++;
			$display("wrong value at %0t: handshake timeout", $time);
			results();
		end
	endtask
	task automatic move(input logic rev);
		wait_on(0);
		mv_rev = rev;
		mv_req = 1'b1;
		tick(1);
		mv_req = 1'b0;
		exp_pos += rev ? -1 : 1;
		exp_err += rev ? -1 : 1;
	endtask
	task automatic feedback(input logic rev);
		fb_dir = rev;
		fb_step = 1'b1;
		tick(1);
		fb_step = 1'b0;
		tick(1);
		exp_err += rev ? 1 : -1;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{sys_rst, form, clr_form, filt, fb_step, fb_dir} = {1'b1, 4'h0, 2'h0, 3'h0};
		{en_req, mv_req, mv_rev, clr_req, clr_pol} = 5'h00;
		{seed, err_count, samples_checked, exp_pos, exp_err} = {32'h50d695e1, 128'h0};
		tick(16);
		sys_rst = 1'b0;
		en_req = 1'b1;
		for (i = 0; i < 10; i++) begin
			form = i[3:0];
			filt = 1'($random(seed));
			tick(50);
			repeat (6) move(1'($random(seed)));
			feedback(1'($random(seed)));
			tick(700);
			chk(pos_q, exp_pos, "position");
			chk(err_q, exp_err, "error count");
			$display("test form %0d done", i);
		end
		for (i = 0; i < 4; i++) begin
			clr_form = i[1:0];
			clr_pol = i[1];
			tick(50);
			wait_on(1);
			move(1'b0);
			tick(700);
			clr_req = 1'b1;
			tick(1);
			clr_req = 1'b0;
			tick(300);
			if (!i[0]) chk({{(`PRD_ERR_W-1){1'b0}}, inh_q}, 1, "inhibit");
			feedback(1'b0);
			feedback(1'b0);
			wait_on(1);
			tick(50);
			exp_err = i[0] ? -2 : 0;
			chk(err_q, exp_err, "cleared count");
			$display("test clear form %0d done", i);
		end
		results();
	end
endmodule
